// ===== src/mbs_pkg.sv
package mbs_pkg;

    // Widths and depths
    localparam int WORD_W        = 16;
    localparam int UADDR_W       = 10;
    localparam int UWORD_W       = 26;
    localparam int USTORE_DEPTH  = 552;
    localparam int CHIP_ID_W     = 5;
    localparam int MAX_SEQ_CHIPS = 32;
    localparam int RF_DEPTH      = 8;
    localparam int PA_W          = 18;

    // Relocation unit register space
    localparam int FP_REGS      = 36;
    localparam int KPAGE_IDX    = 36;
    localparam int UPAGE_IDX    = 44;
    localparam int RELOC_REGS   = 52;
    localparam int PAGE_SHIFT   = 6;
    localparam int PAGE_OFS_W   = 13;
    localparam int PAGE_BASE_W  = 12;

    // Microaddresses and reset values
    localparam logic [9:0]  RESET_UADDR  = 10'h000;
    localparam logic [9:0]  TRAP_UADDR   = 10'h008;
    localparam logic [9:0]  SVC_UADDR    = 10'h010;
    localparam logic [4:0]  BOOT_CHIP_ID = 5'h00;
    localparam logic [15:0] NOP_UINST    = 16'hf000;

    // Microinstruction field positions
    localparam int F_KIND_LO = 14;
    localparam int F_OP_LO   = 11;
    localparam int F_DST_LO  = 8;
    localparam int F_SRCA_LO = 5;
    localparam int F_SRCB_LO = 2;
    localparam int F_SEQ_LO  = 12;
    localparam int F_RSEL    = 13;
    localparam int F_ADDR    = 12;
    localparam int F_USER    = 11;
    localparam int F_NEXT_LO = 16;

    typedef enum logic {PH_HIGH, PH_LOW} mbs_phase_t;

    typedef enum logic [1:0] {K_ALU, K_OUT, K_IN, K_SEQ} mbs_kind_t;

    typedef enum logic [1:0] {
        SQ_JUMP, SQ_JZERO, SQ_CHIPSEL, SQ_FETCH
    } mbs_seqop_t;

    typedef enum logic [2:0] {
        AO_ADD, AO_SUB, AO_AND, AO_OR, AO_XOR, AO_MOVA, AO_INCA, AO_NOTA
    } mbs_aluop_t;

endpackage

// ===== src/mbs_reloc.sv
`timescale 1ns/10ps
module mbs_reloc (
    // Clock
    input  wire logic        sys_clk,
    // Presence strap
    input  wire logic        present_i,
    // Register write
    input  wire logic        wr_en_i,
    input  wire logic [5:0]  wr_idx_i,
    input  wire logic [15:0] wr_data_i,
    // Register read
    input  wire logic [5:0]  rd_idx_i,
    output logic      [15:0] rd_data_o,
    // Address mapping
    input  wire logic [15:0] va_i,
    input  wire logic        user_i,
    output logic      [17:0] pa_o
);
    logic [15:0] regs [0:mbs_pkg::RELOC_REGS-1];
    logic [5:0]  page_idx;
    logic [15:0] base;

    always_ff @(posedge sys_clk) begin
        if (wr_en_i && present_i && wr_idx_i < 6'(mbs_pkg::RELOC_REGS)) begin
            regs[wr_idx_i] <= wr_data_i;
        end
    end

    always_comb begin
        page_idx = user_i ? 6'(mbs_pkg::UPAGE_IDX) : 6'(mbs_pkg::KPAGE_IDX);
        page_idx = page_idx + {3'h0, va_i[15:mbs_pkg::PAGE_OFS_W]};
        base     = regs[page_idx];
        rd_data_o = 16'h0000;
        if (present_i && rd_idx_i < 6'(mbs_pkg::RELOC_REGS)) begin
            rd_data_o = regs[rd_idx_i];
        end
        // Absent unit: identity map, so only 64K words are reachable
        if (present_i) begin
            pa_o = {base[mbs_pkg::PAGE_BASE_W-1:0], 6'h00}
                 + {5'h00, va_i[mbs_pkg::PAGE_OFS_W-1:0]};
        end else begin
            pa_o = {2'h0, va_i};
        end
    end
endmodule

// ===== src/mbs_core.sv
// Notes on behaviour
// - Each cycle takes one 16-bit microinstruction
// - High phase reads and latches ALU operands
// - High phase decodes control word onto bus
// - Low phase finishes ALU, writes destination
// - Output ops drive source register, bypassing ALU
// - Input captured high phase, written low phase
// - Sequencer holds 552 local microstore words
// - Next address from field or branch target
// - Next word fetched while current executes
// - Service requests steer the microprogram sequence
// - Up to 32 cascaded sequencers, one active
// - Active sequencer holds select line low
// - Floating select line flags error, traps to 008
// - Relocation maps user/kernel to 18 bits
// - Physical address replaces virtual on lines
// - Relocation unit holds fifty-two 16-bit registers
// - Without relocation: 64K words, no FP
// - High phase: data on address lines
// - Low phase: service requests on address lines
// - High phase: control word on microinstruction bus
// - Low phase: active sequencer drives microinstruction
`timescale 1ns/10ps
module mbs_core (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Straps
    input  wire logic [4:0]  chip_id_i,
    input  wire logic        reloc_present_i,
    // Microstore load port
    input  wire logic        ustore_we_i,
    input  wire logic [9:0]  ustore_addr_i,
    input  wire logic [25:0] ustore_data_i,
    // Microinstruction bus
    input  wire logic [15:0] microinstruction_bus_i,
    output logic      [15:0] microinstruction_bus_o,
    output logic             microinstruction_bus_oe,
    // Data-address lines
    input  wire logic [15:0] data_address_lines_i,
    output logic      [15:0] data_address_lines_o,
    output logic             data_address_lines_oe,
    output logic      [1:0]  phys_addr_hi_o,
    // Sequencer select line, open drain
    input  wire logic        sequencer_select_line_i,
    output logic             sequencer_select_line_o,
    output logic             sequencer_select_line_oe,
    // Status
    output logic             proc_clk_o,
    output logic             seq_err_o
);

    typedef struct packed {
        mbs_pkg::mbs_phase_t phase;
        logic [15:0]         cur_uinst;
        logic [9:0]          cur_next;
        logic [9:0]          upc;
        logic [9:0]          fetched_next;
        logic [15:0]         opa;
        logic [15:0]         opb;
        logic [15:0]         in_data;
        logic [15:0]         svc;
        logic                zero;
        logic                active;
        logic                err;
        logic [15:0]         mib_o;
        logic                mib_oe;
        logic [15:0]         lines_o;
        logic                lines_oe;
        logic [1:0]          pa_hi;
        logic                sel_lvl;
        logic                sel_oe;
        logic                clk_o;
    } mbs_core_state_t;

    mbs_core_state_t s_ff;
    mbs_core_state_t nxt_s;

    // Local microstore and register file
    logic [25:0] ustore [0:mbs_pkg::USTORE_DEPTH-1];
    logic [15:0] rf     [0:mbs_pkg::RF_DEPTH-1];

    logic                rf_we;
    logic [2:0]          rf_widx;
    logic [15:0]         rf_wdata;
    logic                rel_we;
    logic [15:0]         rel_rd;
    logic [17:0]         rel_pa;
    logic [15:0]         alu_res;
    logic [15:0]         next_uinst;
    logic [9:0]          fetch_addr;
    logic [25:0]         fetch_word;
    mbs_pkg::mbs_kind_t  cur_kind;
    mbs_pkg::mbs_kind_t  new_kind;
    mbs_pkg::mbs_seqop_t cur_seq;

    // Output path bypass
    logic [2:0]          out_idx;
    logic                wb_hit;
    logic [15:0]         out_src;

    function automatic mbs_pkg::mbs_kind_t f_kind(input logic [15:0] u);
        f_kind = mbs_pkg::mbs_kind_t'(u[mbs_pkg::F_KIND_LO +: 2]);
    endfunction

    function automatic logic [2:0] f_reg(input logic [15:0] u,
                                         input int          lo);
        f_reg = u[lo +: 3];
    endfunction

    // Control word seen by the board and other chips in the high phase
    function automatic logic [15:0] f_ctrl(input logic [15:0] u);
        logic is_out;
        logic is_in;
        is_out = (f_kind(u) == mbs_pkg::K_OUT);
        is_in  = (f_kind(u) == mbs_pkg::K_IN);
        f_ctrl = {is_out & u[mbs_pkg::F_ADDR], is_in, is_out,
                  u[mbs_pkg::F_RSEL], u[11:0]};
    endfunction

    function automatic logic [15:0] f_alu(input mbs_pkg::mbs_aluop_t op,
                                          input logic [15:0]         a,
                                          input logic [15:0]         b);
        case (op)
            mbs_pkg::AO_ADD:  f_alu = a + b;
            mbs_pkg::AO_SUB:  f_alu = a - b;
            mbs_pkg::AO_AND:  f_alu = a & b;
            mbs_pkg::AO_OR:   f_alu = a | b;
            mbs_pkg::AO_XOR:  f_alu = a ^ b;
            mbs_pkg::AO_MOVA: f_alu = a;
            mbs_pkg::AO_INCA: f_alu = a + 16'h0001;
            mbs_pkg::AO_NOTA: f_alu = ~a;
            default:          f_alu = a;
        endcase
    endfunction

    // While inactive, the bus carries the active chip's word
    assign next_uinst = s_ff.mib_oe ? s_ff.mib_o
                                    : microinstruction_bus_i;

    assign cur_kind = f_kind(s_ff.cur_uinst);
    assign new_kind = f_kind(next_uinst);
    assign cur_seq  = mbs_pkg::mbs_seqop_t'(
                          s_ff.cur_uinst[mbs_pkg::F_SEQ_LO +: 2]);

    assign alu_res = f_alu(mbs_pkg::mbs_aluop_t'(
                               s_ff.cur_uinst[mbs_pkg::F_OP_LO +: 3]),
                           s_ff.opa, s_ff.opb);

    // An output or address step reads this register
    assign out_idx = f_reg(next_uinst, mbs_pkg::F_DST_LO);

    // The write that ends this low phase lands in rf only at the edge,
    // but the word put on the lines at that edge must already see it
    assign wb_hit = (s_ff.phase == mbs_pkg::PH_LOW)
                    && (f_reg(s_ff.cur_uinst, mbs_pkg::F_DST_LO) == out_idx);

    always_comb begin
        out_src = rf[out_idx];
        if (wb_hit && cur_kind == mbs_pkg::K_ALU) begin
            out_src = alu_res;
        end else if (wb_hit && cur_kind == mbs_pkg::K_IN
                     && !s_ff.cur_uinst[mbs_pkg::F_RSEL]) begin
            out_src = s_ff.in_data;
        end
    end

    mbs_reloc u_reloc (
        .sys_clk   (sys_clk),
        .present_i (reloc_present_i),
        .wr_en_i   (rel_we),
        .wr_idx_i  (s_ff.cur_uinst[5:0]),
        .wr_data_i (s_ff.in_data),
        .rd_idx_i  (next_uinst[5:0]),
        .rd_data_o (rel_rd),
        .va_i      (out_src),
        .user_i    (next_uinst[mbs_pkg::F_USER]),
        .pa_o      (rel_pa)
    );

    always_comb begin
        nxt_s      = s_ff;
        rf_we      = 1'b0;
        rf_widx    = f_reg(s_ff.cur_uinst, mbs_pkg::F_DST_LO);
        rf_wdata   = alu_res;
        rel_we     = 1'b0;
        fetch_addr = s_ff.cur_next;
        fetch_word = '0;

        case (s_ff.phase)
            mbs_pkg::PH_HIGH: begin
                nxt_s.phase = mbs_pkg::PH_LOW;
                nxt_s.clk_o = 1'b0;

                nxt_s.opa = rf[f_reg(s_ff.cur_uinst, mbs_pkg::F_SRCA_LO)];
                nxt_s.opb = rf[f_reg(s_ff.cur_uinst, mbs_pkg::F_SRCB_LO)];

                if (cur_kind == mbs_pkg::K_IN) begin
                    nxt_s.in_data = data_address_lines_i;
                end

                if (cur_kind == mbs_pkg::K_SEQ) begin
                    case (cur_seq)
                        mbs_pkg::SQ_JUMP: begin
                            fetch_addr = s_ff.cur_uinst[9:0];
                        end
                        // Flag left by the last ALU step; inputs keep it
                        mbs_pkg::SQ_JZERO: begin
                            if (s_ff.zero) begin
                                fetch_addr = s_ff.cur_uinst[9:0];
                            end
                        end
                        mbs_pkg::SQ_CHIPSEL: begin
                            nxt_s.active = (s_ff.cur_uinst[4:0]
                                            == chip_id_i);
                            // A chip waking up has no valid next field
                            if (!s_ff.active) begin
                                fetch_addr = mbs_pkg::RESET_UADDR;
                            end
                            nxt_s.err = 1'b0;
                        end
                        mbs_pkg::SQ_FETCH: begin
                            if (s_ff.svc != 16'h0000) begin
                                fetch_addr = mbs_pkg::SVC_UADDR;
                            end
                        end
                        default: begin
                            fetch_addr = s_ff.cur_next;
                        end
                    endcase
                end

                // Nobody pulls the line low: the boot chip takes the trap
                if (sequencer_select_line_i
                    && chip_id_i == mbs_pkg::BOOT_CHIP_ID) begin
                    nxt_s.err    = 1'b1;
                    nxt_s.active = 1'b1;
                    fetch_addr   = mbs_pkg::TRAP_UADDR;
                end

                // Fetch overlaps execution of the current word
                if (fetch_addr < 10'(mbs_pkg::USTORE_DEPTH)) begin
                    fetch_word = ustore[fetch_addr];
                end
                nxt_s.upc          = fetch_addr;
                nxt_s.fetched_next = fetch_word[mbs_pkg::F_NEXT_LO +: 10];

                nxt_s.mib_oe   = nxt_s.active;
                nxt_s.mib_o    = nxt_s.active ? fetch_word[15:0]
                                              : 16'h0000;
                nxt_s.lines_oe = 1'b0;
                nxt_s.lines_o  = 16'h0000;
                nxt_s.sel_oe   = nxt_s.active;
            end

            mbs_pkg::PH_LOW: begin
                nxt_s.phase = mbs_pkg::PH_HIGH;
                nxt_s.clk_o = 1'b1;

                if (cur_kind == mbs_pkg::K_ALU) begin
                    rf_we      = 1'b1;
                    nxt_s.zero = (alu_res == 16'h0000);
                end
                if (cur_kind == mbs_pkg::K_IN) begin
                    if (s_ff.cur_uinst[mbs_pkg::F_RSEL]) begin
                        rel_we = 1'b1;
                    end else begin
                        rf_we    = 1'b1;
                        rf_wdata = s_ff.in_data;
                    end
                end

                nxt_s.svc = data_address_lines_i;

                nxt_s.cur_uinst = next_uinst;
                nxt_s.cur_next  = s_ff.fetched_next;

                nxt_s.mib_oe = 1'b1;
                nxt_s.mib_o  = f_ctrl(next_uinst);

                nxt_s.lines_oe = 1'b0;
                nxt_s.lines_o  = 16'h0000;
                nxt_s.pa_hi    = 2'h0;
                if (new_kind == mbs_pkg::K_OUT) begin
                    nxt_s.lines_oe = 1'b1;
                    if (next_uinst[mbs_pkg::F_ADDR]) begin
                        nxt_s.lines_o = rel_pa[15:0];
                        nxt_s.pa_hi   = rel_pa[17:16];
                    end else if (next_uinst[mbs_pkg::F_RSEL]) begin
                        nxt_s.lines_o = rel_rd;
                    end else begin
                        // Source goes straight out, the ALU is not used
                        nxt_s.lines_o = out_src;
                    end
                end
                nxt_s.sel_oe = s_ff.active;
            end

            default: begin
                nxt_s.phase = mbs_pkg::PH_HIGH;
            end
        endcase

        // Start in a high phase on a no-op that falls into the reset word
        if (sys_rst) begin
            nxt_s           = '0;
            nxt_s.phase     = mbs_pkg::PH_HIGH;
            nxt_s.clk_o     = 1'b1;
            nxt_s.cur_uinst = mbs_pkg::NOP_UINST;
            nxt_s.cur_next  = mbs_pkg::RESET_UADDR;
            nxt_s.upc       = mbs_pkg::RESET_UADDR;
            nxt_s.active    = (chip_id_i == mbs_pkg::BOOT_CHIP_ID);
            nxt_s.sel_oe    = (chip_id_i == mbs_pkg::BOOT_CHIP_ID);
        end
    end

    always_ff @(posedge sys_clk) begin
        s_ff <= nxt_s;
    end

    // Memories carry no reset; software must load the microstore first
    always_ff @(posedge sys_clk) begin
        if (ustore_we_i && ustore_addr_i < 10'(mbs_pkg::USTORE_DEPTH)) begin
            ustore[ustore_addr_i] <= ustore_data_i;
        end
        if (rf_we) begin
            rf[rf_widx] <= rf_wdata;
        end
    end

    assign microinstruction_bus_o   = s_ff.mib_o;
    assign microinstruction_bus_oe  = s_ff.mib_oe;
    assign data_address_lines_o     = s_ff.lines_o;
    assign data_address_lines_oe    = s_ff.lines_oe;
    assign phys_addr_hi_o           = s_ff.pa_hi;
    // The select pin is open drain: the board's pull-up gives the high
    // level, so this chip only ever pulls low or lets go
    assign sequencer_select_line_o  = s_ff.sel_lvl;
    assign sequencer_select_line_oe = s_ff.sel_oe;
    assign proc_clk_o               = s_ff.clk_o;
    assign seq_err_o                = s_ff.err;

endmodule

// ===== sim/mbs_core_sva.sv
`timescale 1ns/10ps
module mbs_core_sva (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // Straps
    input wire logic [4:0]  chip_id_i,
    input wire logic        reloc_present_i,
    // Buses
    input wire logic [15:0] microinstruction_bus_o,
    input wire logic        microinstruction_bus_oe,
    input wire logic        data_address_lines_oe,
    input wire logic [1:0]  phys_addr_hi_o,
    input wire logic        sequencer_select_line_i,
    // Status
    input wire logic        proc_clk_o,
    input wire logic        seq_err_o
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_phase_alt: assert property (!sys_rst |=>
        proc_clk_o != $past(proc_clk_o))
        else $error("processor phase did not alternate");
    a_ctrl_drive: assert property (!proc_clk_o ##1 proc_clk_o |->
        microinstruction_bus_oe)
        else $error("control word not driven in high phase");
    a_lines_free: assert property (!proc_clk_o |->
        !data_address_lines_oe)
        else $error("address lines driven in low phase");
    a_out_drive: assert property ($rose(proc_clk_o) |->
        data_address_lines_oe == microinstruction_bus_o[13])
        else $error("line enable disagrees with output flag");
    a_err_set: assert property (proc_clk_o && sequencer_select_line_i
        && chip_id_i == 5'h00 |=> seq_err_o)
        else $error("floating select line not flagged");
    a_err_cause: assert property ($rose(seq_err_o) |->
        $past(sequencer_select_line_i) && !proc_clk_o)
        else $error("error flag rose without floating select");
    a_err_trap: assert property ($rose(seq_err_o) |->
        microinstruction_bus_oe ##1 microinstruction_bus_oe)
        else $error("boot chip not active after error");
    a_no_reloc: assert property (!reloc_present_i &&
        data_address_lines_oe |-> phys_addr_hi_o == 2'h0)
        else $error("high address bits set without relocation");

    c_addr_cycle: cover property (microinstruction_bus_o[15]
        && data_address_lines_oe);
    c_err: cover property ($rose(seq_err_o));
    c_input: cover property (proc_clk_o && microinstruction_bus_o[14]);
endmodule

// ===== sim/mbs_board.sv
`timescale 1ns/10ps
module mbs_board (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Core outputs
    input  wire logic        proc_clk_o,
    input  wire logic [15:0] microinstruction_bus_o,
    input  wire logic        microinstruction_bus_oe,
    input  wire logic [15:0] data_address_lines_o,
    input  wire logic        data_address_lines_oe,
    input  wire logic        sequencer_select_line_o,
    input  wire logic        sequencer_select_line_oe,
    // Board stimulus
    input  wire logic [15:0] din_a,
    input  wire logic [15:0] din_b,
    input  wire logic [15:0] svc_word,
    // Wire levels
    output logic      [15:0] microinstruction_bus_i,
    output logic      [15:0] data_address_lines_i,
    output logic             sequencer_select_line_i
);
    logic        in_cnt_ff;
    logic [11:0] rel_ff;

    // Released bus moves every cycle so a stale word is never reused
    assign microinstruction_bus_i = microinstruction_bus_oe ?
        microinstruction_bus_o : {4'hf, rel_ff};
    // Pull-up wins when no chip pulls low
    assign sequencer_select_line_i = sequencer_select_line_oe ?
        sequencer_select_line_o : 1'b1;
    assign data_address_lines_i = data_address_lines_oe ?
        data_address_lines_o : proc_clk_o ?
        (in_cnt_ff ? din_b : din_a) : svc_word;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_cnt_ff <= 1'b0;
            rel_ff    <= 12'h000;
        end else begin
            rel_ff <= rel_ff + 12'h001;
            if (proc_clk_o && microinstruction_bus_o[14]) begin
                in_cnt_ff <= ~in_cnt_ff;
            end
        end
    end
endmodule

// ===== sim/mbs_core_bench.sv
`timescale 1ns/10ps
module mbs_core_bench;
    typedef struct packed {
        logic [2:0]  op;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] y;
    } mbs_row_t;
    mbs_row_t rows [8] = '{
        '{3'h0, 16'h00f0, 16'h0f0f, 16'h0fff},
        '{3'h1, 16'h0001, 16'h0002, 16'hffff},
        '{3'h2, 16'hff00, 16'h0ff0, 16'h0f00},
        '{3'h3, 16'h00f0, 16'h0f0f, 16'h0fff},
        '{3'h4, 16'hffff, 16'h0f0f, 16'hf0f0},
        '{3'h5, 16'h1234, 16'hffff, 16'h1234},
        '{3'h6, 16'hffff, 16'h0000, 16'h0000},
        '{3'h7, 16'h00f0, 16'h0000, 16'hff0f}};
    logic        sys_clk;
    logic        sys_rst;
    logic [4:0]  chip_id_i;
    logic        reloc_present_i;
    logic        ustore_we_i;
    logic [9:0]  ustore_addr_i;
    logic [25:0] ustore_data_i;
    logic [15:0] microinstruction_bus_i;
    logic [15:0] microinstruction_bus_o;
    logic        microinstruction_bus_oe;
    logic [15:0] data_address_lines_i;
    logic [15:0] data_address_lines_o;
    logic        data_address_lines_oe;
    logic [1:0]  phys_addr_hi_o;
    logic        sequencer_select_line_i;
    logic        sequencer_select_line_o;
    logic        sequencer_select_line_oe;
    logic        proc_clk_o;
    logic        seq_err_o;
    logic [15:0] din_a;
    logic [15:0] din_b;
    logic [15:0] svc_word;
    logic [17:0] pa_exp;
    logic        hit;
    int          miscompares;
    int          checks;

    mbs_core i_dut (.*);
    mbs_board i_board (.*);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [17:0] e,
                       input logic [17:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {17'h0, e}, {17'h0, g});
    endtask

    // Bounded search for a driven word in the given phase
    task automatic seek(input logic ph, input logic [15:0] w);
        hit = 1'b0;
        for (int k = 0; k < 40 && !hit; k++) begin
            @(posedge sys_clk);
            #1;
            hit = proc_clk_o === ph && microinstruction_bus_oe === 1'b1
                  && microinstruction_bus_o === w;
        end
        chkb("bus word", 1'b1, hit);
    endtask

    task automatic hold_rst();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic ld(input logic [9:0] a, input logic [9:0] nx,
                      input logic [15:0] u);
        @(posedge sys_clk);
        ustore_we_i   <= 1'b1;
        ustore_addr_i <= a;
        ustore_data_i <= {nx, u};
        @(posedge sys_clk);
        ustore_we_i   <= 1'b0;
    endtask

    task automatic go();
        @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        results();
    end

    initial begin
        miscompares = 0;
        checks = 0;
        sys_rst         <= 1'b1;
        chip_id_i       <= 5'h00;
        reloc_present_i <= 1'b1;
        ustore_we_i     <= 1'b0;
        ustore_addr_i   <= 10'h000;
        ustore_data_i   <= 26'h0000000;
        din_a           <= 16'h0000;
        din_b           <= 16'h0000;
        svc_word        <= 16'h0000;
        repeat (8) @(posedge sys_clk);
        #1;
        chkb("reset phase", 1'b1, proc_clk_o);
        chkb("reset bus oe", 1'b0, microinstruction_bus_oe);
        chkb("reset lines oe", 1'b0, data_address_lines_oe);
        chkb("reset select", 1'b1, sequencer_select_line_oe);
        chkb("select level", 1'b0, sequencer_select_line_o);
        chkb("reset error", 1'b0, seq_err_o);
        foreach (rows[i]) begin
            hold_rst();
            din_a <= rows[i].a;
            din_b <= rows[i].b;
            ld(10'h000, 10'h001, 16'h8100);
            ld(10'h001, 10'h002, 16'h8200);
            ld(10'h002, 10'h003, {2'b00, rows[i].op, 11'h328});
            ld(10'h003, 10'h004, 16'h4300);
            ld(10'h004, 10'h004, 16'hf000);
            ld(10'h010, 10'h010, 16'h4600);
            go();
            seek(1'b1, 16'h4100);
            seek(1'b0, 16'h4300);
            seek(1'b1, 16'h2300);
            chk("alu", {2'h0, rows[i].y}, {2'h0, data_address_lines_o});
            chkb("out enable", 1'b1, data_address_lines_oe);
        end
        seek(1'b0, 16'hf000);
        @(posedge sys_clk);
        svc_word <= 16'h0001;
        seek(1'b0, 16'h4600);
        @(posedge sys_clk);
        svc_word <= 16'h0000;
        // Page 1 is used so a wrong page index shows up
        for (int k = 0; k < 3; k++) begin
            hold_rst();
            reloc_present_i <= (k < 2);
            din_a <= 16'h0c01;
            din_b <= 16'h2123;
            pa_exp = (k < 2) ? 18'h30163 : 18'h02123;
            ld(10'h000, 10'h001, (k == 1) ? 16'ha02d : 16'ha025);
            ld(10'h001, 10'h002, 16'h8100);
            ld(10'h002, 10'h003, (k == 1) ? 16'h5900 : 16'h5100);
            ld(10'h003, 10'h004, (k == 1) ? 16'h602d : 16'h6025);
            ld(10'h004, 10'h004, 16'hf000);
            go();
            seek(1'b1, (k == 1) ? 16'ha900 : 16'ha100);
            chk("pa", pa_exp, {phys_addr_hi_o, data_address_lines_o});
            seek(1'b1, (k == 1) ? 16'h302d : 16'h3025);
            chk("fp reg", (k < 2) ? 18'h00c01 : 18'h00000,
                {2'h0, data_address_lines_o});
        end
        // Zero from r1 xor r1 takes the conditional branch, then a jump
        hold_rst();
        ld(10'h000, 10'h001, 16'h2424);
        ld(10'h001, 10'h002, 16'hd005);
        ld(10'h005, 10'h006, 16'hc007);
        ld(10'h007, 10'h007, 16'h4500);
        go();
        seek(1'b0, 16'hc007);
        seek(1'b0, 16'h4500);
        hold_rst();
        ld(10'h000, 10'h001, 16'he005);
        ld(10'h008, 10'h008, 16'h4700);
        go();
        seek(1'b0, 16'h4700);
        chkb("seq error", 1'b1, seq_err_o);
        results();
    end
endmodule

bind mbs_core mbs_core_sva i_sva (
    .sys_clk, .sys_rst, .chip_id_i, .reloc_present_i,
    .microinstruction_bus_o, .microinstruction_bus_oe,
    .data_address_lines_oe, .phys_addr_hi_o, .sequencer_select_line_i,
    .proc_clk_o, .seq_err_o
);
